// ---- shared/adhr_pkg.sv ----
// constants of the audio decoder host register bank
package adhr_pkg;
   // -------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL    = 8'hAA;
   localparam logic [7:0] ADDR_STREAM     = 8'hAC;
   localparam logic [7:0] ADDR_ANCILLARY  = 8'hAD;
   localparam logic [7:0] ADDR_AUX_STATUS = 8'hAF;
   localparam logic [7:0] ADDR_STATUS     = 8'hC8;
   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET   = 8'h3F;
   localparam logic [7:0] STATUS_RESET    = 8'h01;
   localparam logic [7:0] AUX_RESET       = 8'h11;
   localparam logic [7:0] ANC_RESET       = 8'h00;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int BIT_ENABLE    = 7;
   localparam int BIT_BASS      = 6;
   localparam int BIT_CRC_PLAY  = 5;
   localparam int MASK_HI       = 4;
   localparam int FLAG_ANC      = 7;
   localparam int FLAG_REQ      = 6;
   localparam int FLAG_LAYER    = 5;
   localparam int FLAG_SYNC     = 4;
   localparam int FLAG_CRC      = 3;
   localparam int FLAG_LO       = 3;
   localparam int BIT_RATE_HI   = 2;
   localparam int BIT_RATE_LO   = 1;
   localparam int BIT_VERSION   = 0;
   localparam int AUX_FRAME_REQ = 4;
   localparam int AUX_BYTE_REQ  = 3;
   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int FIRST_FILL_BYTES = 1024;
   localparam int FILL_WIDTH       = 11;
   localparam int ANC_DEPTH        = 16;
   // sampling rate selected by {version, code}
   typedef enum logic [2:0] {
      ADHR_FS_22K05 = 3'h0,
      ADHR_FS_24K   = 3'h1,
      ADHR_FS_16K   = 3'h2,
      ADHR_FS_RSV2  = 3'h3,
      ADHR_FS_44K1  = 3'h4,
      ADHR_FS_48K   = 3'h5,
      ADHR_FS_32K   = 3'h6,
      ADHR_FS_RSV1  = 3'h7
   } adhr_rate_type;
endpackage

// ---- shared/adhr_anc_if.sv ----
// ancillary byte buffer connection between bank and buffer
`timescale 1ns/1ps
`default_nettype none
interface adhr_anc_if #(parameter int WIDTH = 8);
   logic             push;
   logic [WIDTH-1:0] pushData;
   logic             pop;
   logic [WIDTH-1:0] head;
   logic             empty;
   logic             full;
   modport fifo (input push, pushData, pop, output head, empty, full);
   modport user (output push, pushData, pop, input head, empty, full);
endinterface
`default_nettype wire

// ---- core/adhr_anc_fifo.sv ----
// ancillary byte buffer
`timescale 1ns/1ps
`default_nettype none
module adhr_anc_fifo #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   adhr_anc_if.fifo ancPort
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic             doPush;
   logic             doPop;

   assign doPush        = ancPort.push && !ancPort.full;
   assign doPop         = ancPort.pop && !ancPort.empty;
   assign ancPort.empty = (count == '0);
   assign ancPort.full  = (count == (AW+1)'(DEPTH));
   assign ancPort.head  = mem[rdPtr];

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr] <= ancPort.pushData;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (doPop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         if (doPush && !doPop) begin
            count <= count + 1'b1;
         end else if (doPop && !doPush) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- core/adhr_regs.sv ----
// host register bank of the layer-3 audio decoder
`timescale 1ns/1ps
`default_nettype none
module adhr_regs #(
   parameter int FIRST_FILL = adhr_pkg::FIRST_FILL_BYTES,
   parameter int ANC_DEPTH  = adhr_pkg::ANC_DEPTH
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWrData,
   input  wire logic       sfrWr,
   input  wire logic       sfrRd,
   output var  logic [7:0] sfrRdData,
   input  wire logic       decReq,
   input  wire logic       hdrLoad,
   input  wire logic       hdrVersion,
   input  wire logic [1:0] hdrRateCode,
   input  wire logic       layerErr,
   input  wire logic       syncErr,
   input  wire logic       crcErr,
   input  wire logic       ancValid,
   input  wire logic [7:0] ancByte,
   output var  logic       decoderEnable,
   output var  logic       bassBoost,
   output var  logic       crcFramePlay,
   output var  logic       frameSkip,
   output var  logic [7:0] streamByte,
   output var  logic       streamValid,
   output var  logic       fillPending,
   output var  logic       rateReserved,
   output var  logic       decIrq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]                    control;
   logic                          ancFlag;
   logic                          dataReqFlag;
   logic                          layerFlag;
   logic                          syncFlag;
   logic                          crcFlag;
   logic [1:0]                    rateCode;
   logic                          versionBit;
   logic                          frameReq;
   logic                          byteReq;
   logic                          enPrev;
   logic                          reqPrev;
   logic [adhr_pkg::FILL_WIDTH-1:0] fillCount;
   logic [7:0]                    next_rdData;
   logic [7:0]                    statusValue;
   logic [7:0]                    auxValue;
   logic                          ctrlWr;
   logic                          streamWr;
   logic                          statusRd;
   logic                          ancRd;
   logic                          requesting;
   logic                          reqRise;
   logic                          enableRise;
   adhr_pkg::adhr_rate_type       rateSel;

   adhr_anc_if #(.WIDTH(8)) ancBus ();

   adhr_anc_fifo #(
      .DEPTH (ANC_DEPTH),
      .WIDTH (8)
   ) ancBuffer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ancPort (ancBus.fifo)
   );

   // ----------------------------------------------------------------
   // decode and events
   // ----------------------------------------------------------------
   assign ctrlWr     = sfrWr && (sfrAddr == adhr_pkg::ADDR_CONTROL);
   assign streamWr   = sfrWr && (sfrAddr == adhr_pkg::ADDR_STREAM);
   assign statusRd   = sfrRd && (sfrAddr == adhr_pkg::ADDR_STATUS);
   assign ancRd      = sfrRd && (sfrAddr == adhr_pkg::ADDR_ANCILLARY);
   assign enableRise = control[adhr_pkg::BIT_ENABLE] && !enPrev;
   assign requesting = control[adhr_pkg::BIT_ENABLE]
                       && (decReq || fillCount != '0);
   assign reqRise    = requesting && !reqPrev;
   assign rateSel    = adhr_pkg::adhr_rate_type'({versionBit, rateCode});

   assign ancBus.push     = ancValid;
   assign ancBus.pushData = ancByte;
   assign ancBus.pop      = ancRd;

   assign statusValue = {ancFlag, dataReqFlag, layerFlag, syncFlag,
                         crcFlag, rateCode, versionBit};
   assign auxValue    = {3'h0, frameReq, byteReq, 3'h0};

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         control <= adhr_pkg::CONTROL_RESET;
      end else if (ctrlWr) begin
         control <= sfrWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         decoderEnable <= 1'b0;
         bassBoost     <= 1'b0;
         crcFramePlay  <= 1'b0;
         enPrev        <= 1'b0;
      end else begin
         decoderEnable <= control[adhr_pkg::BIT_ENABLE];
         bassBoost     <= control[adhr_pkg::BIT_BASS];
         crcFramePlay  <= control[adhr_pkg::BIT_CRC_PLAY];
         enPrev        <= control[adhr_pkg::BIT_ENABLE];
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ancFlag <= 1'b0;
      end else begin
         ancFlag <= !ancBus.empty;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dataReqFlag <= 1'b0;
         layerFlag   <= 1'b0;
         syncFlag    <= 1'b0;
         crcFlag     <= 1'b0;
      end else begin
         // a set in the read cycle wins over the clear
         if (reqRise) begin
            dataReqFlag <= 1'b1;
         end else if (statusRd) begin
            dataReqFlag <= 1'b0;
         end
         if (layerErr && decoderEnable) begin
            layerFlag <= 1'b1;
         end else if (statusRd) begin
            layerFlag <= 1'b0;
         end
         if (syncErr && decoderEnable) begin
            syncFlag <= 1'b1;
         end else if (statusRd) begin
            syncFlag <= 1'b0;
         end
         if (crcErr && decoderEnable) begin
            crcFlag <= 1'b1;
         end else if (statusRd) begin
            crcFlag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         versionBit <= adhr_pkg::STATUS_RESET[adhr_pkg::BIT_VERSION];
         rateCode   <= adhr_pkg::STATUS_RESET[adhr_pkg::BIT_RATE_HI:adhr_pkg::BIT_RATE_LO];
      end else if (hdrLoad && decoderEnable) begin
         versionBit <= hdrVersion;
         rateCode   <= hdrRateCode;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rateReserved <= 1'b0;
      end else begin
         rateReserved <= (rateSel == adhr_pkg::ADHR_FS_RSV1)
                         || (rateSel == adhr_pkg::ADHR_FS_RSV2);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         decIrq <= 1'b0;
      end else begin
         decIrq <= |(statusValue[adhr_pkg::FLAG_ANC:adhr_pkg::FLAG_LO]
                     & ~control[adhr_pkg::MASK_HI:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frameSkip <= 1'b0;
      end else begin
         frameSkip <= crcErr && decoderEnable
                      && !control[adhr_pkg::BIT_CRC_PLAY];
      end
   end

   // ----------------------------------------------------------------
   // data request handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fillCount <= '0;
      end else if (!control[adhr_pkg::BIT_ENABLE]) begin
         fillCount <= '0;
      end else if (enableRise) begin
         fillCount <= adhr_pkg::FILL_WIDTH'(FIRST_FILL);
      end else if (streamWr && fillCount != '0) begin
         fillCount <= fillCount - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fillPending <= 1'b0;
         reqPrev     <= 1'b0;
      end else begin
         fillPending <= (fillCount != '0);
         reqPrev     <= requesting;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frameReq <= adhr_pkg::AUX_RESET[adhr_pkg::AUX_FRAME_REQ];
      end else if (control[adhr_pkg::BIT_ENABLE]) begin
         frameReq <= requesting;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         byteReq <= adhr_pkg::AUX_RESET[adhr_pkg::AUX_BYTE_REQ];
      end else if (streamWr) begin
         byteReq <= 1'b0;
      end else if (requesting) begin
         byteReq <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // stream input and read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         streamByte  <= 8'h00;
         streamValid <= 1'b0;
      end else begin
         streamValid <= streamWr;
         if (streamWr) begin
            streamByte <= sfrWrData;
         end
      end
   end

   always_comb begin
      next_rdData = 8'h00;
      unique case (sfrAddr)
         adhr_pkg::ADDR_CONTROL:    next_rdData = control;
         adhr_pkg::ADDR_STATUS:     next_rdData = statusValue;
         adhr_pkg::ADDR_AUX_STATUS: next_rdData = auxValue;
         adhr_pkg::ADDR_ANCILLARY: begin
            // an empty buffer presents zero
            next_rdData = ancBus.empty ? adhr_pkg::ANC_RESET
                                       : ancBus.head;
         end
         default:                   next_rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sfrRdData <= 8'h00;
      end else if (sfrRd) begin
         sfrRdData <= next_rdData;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   localparam logic [adhr_pkg::FILL_WIDTH-1:0] FILL_WIDTH_CHECK =
      adhr_pkg::FILL_WIDTH'(FIRST_FILL);

   enable_follow_a: assert property (ctrlWr |=> ##1
      decoderEnable == $past(sfrWrData[7], 2))
      else $error("enable output does not follow control bit 7");
   bass_follow_a: assert property (ctrlWr |=> ##1
      bassBoost == $past(sfrWrData[6], 2))
      else $error("bass boost does not follow control bit 6");
   crc_skip_a: assert property (
      crcErr && decoderEnable && !control[5] |=> frameSkip)
      else $error("bad CRC frame not skipped");
   irq_mask_a: assert property (
      1'b1 |=> decIrq == |($past(statusValue[7:3]) & ~$past(control[4:0])))
      else $error("interrupt does not match flags and masks");
   anc_flag_a: assert property (
      ancValid && !ancBus.full |=> ##1 ancFlag)
      else $error("ancillary flag not set after push");
   req_set_a: assert property (reqRise |=> dataReqFlag)
      else $error("request flag lost");
   req_clear_a: assert property (
      statusRd && !reqRise && dataReqFlag |=> !dataReqFlag)
      else $error("request flag not cleared by status read");
   layer_flag_a: assert property (
      layerErr && decoderEnable |=> layerFlag)
      else $error("layer error flag not set");
   sync_flag_a: assert property (
      syncErr && decoderEnable |=> syncFlag)
      else $error("sync error flag not set");
   crc_flag_a: assert property (
      crcErr && decoderEnable |=> crcFlag ##1 (crcFlag || $past(statusRd)))
      else $error("crc flag not set or not held");
   hdr_load_a: assert property (
      hdrLoad && decoderEnable |=> versionBit == $past(hdrVersion)
      && rateCode == $past(hdrRateCode))
      else $error("header fields not loaded");
   stream_out_a: assert property (
      streamWr |=> streamValid && streamByte == $past(sfrWrData))
      else $error("stream byte not forwarded");
   frame_req_a: assert property (
      requesting |=> frameReq)
      else $error("frame request flag not set while requesting");
   byte_clear_a: assert property (
      streamWr |=> !byteReq)
      else $error("byte request not cleared by stream write");
   fill_load_a: assert property (
      enableRise |=> fillCount == FILL_WIDTH_CHECK)
      else $error("first fill count wrong");
   aux_zero_a: assert property (
      sfrRd && sfrAddr == adhr_pkg::ADDR_AUX_STATUS |=> sfrRdData[7:5] == 3'h0
      && sfrRdData[2:0] == 3'h0)
      else $error("unused aux bits read nonzero");
   anc_pop_a: assert property (
      ancRd && !ancBus.empty |=> sfrRdData == $past(ancBus.head))
      else $error("ancillary read does not present head byte");

   first_fill_c: cover property (enableRise ##1 fillCount != '0);
   anc_pop_c: cover property (ancFlag && ancRd);
   status_clear_c: cover property (crcFlag && statusRd ##1 !crcFlag);
   irq_raise_c: cover property (!decIrq ##1 decIrq);
   fill_done_c: cover property (fillPending ##1 !fillPending);
endmodule
`default_nettype wire

// ---- bench/adhr_dec_model.sv ----
// decoder datapath model feeding the bank's decoder-side inputs
`timescale 1ns/1ps
`default_nettype none
module adhr_dec_model (
   input  wire logic       clk,
   output var  logic       decReq,
   output var  logic       hdrLoad,
   output var  logic       hdrVersion,
   output var  logic [1:0] hdrRateCode,
   output var  logic       layerErr,
   output var  logic       syncErr,
   output var  logic       crcErr,
   output var  logic       ancValid,
   output var  logic [7:0] ancByte
);
   // ---------------------------------------------------------------
   // event tasks, launched just after a rising edge
   // ---------------------------------------------------------------
   // quiet levels, applied by the bench while reset is held
   task automatic idle;
      decReq <= 1'b0;
      hdrLoad <= 1'b0;
      hdrVersion <= 1'b0;
      hdrRateCode <= 2'h0;
      {layerErr, syncErr, crcErr} <= 3'h0;
      ancValid <= 1'b0;
      ancByte <= 8'h00;
   endtask
   task automatic set_req(input logic v);
      @(posedge clk);
      decReq <= v;
   endtask
   // sel is {layer, sync, crc}
   task automatic pulse_err(input logic [2:0] sel);
      @(posedge clk);
      {layerErr, syncErr, crcErr} <= sel;
      @(posedge clk);
      {layerErr, syncErr, crcErr} <= 3'h0;
   endtask
   // header fields go stale once the load pulse is over
   task automatic load_hdr(input logic [2:0] vc);
      @(posedge clk);
      hdrLoad <= 1'b1;
      hdrVersion <= vc[2];
      hdrRateCode <= vc[1:0];
      @(posedge clk);
      hdrLoad <= 1'b0;
      hdrVersion <= ~vc[2];
      hdrRateCode <= ~vc[1:0];
   endtask
   task automatic push_anc(input logic [7:0] b);
      @(posedge clk);
      ancValid <= 1'b1;
      ancByte <= b;
      @(posedge clk);
      ancValid <= 1'b0;
      ancByte <= ~b;
   endtask
endmodule
`default_nettype wire

// ---- bench/audio_decoder_host_regs_tb_top.sv ----
// self-checking bench of the audio decoder host register bank
`timescale 1ns/1ps
`default_nettype none
module audio_decoder_host_regs_tb_top;
   logic       clk;
   logic       sysRst;
   logic [7:0] sfrAddr;
   logic [7:0] sfrWrData;
   logic       sfrWr;
   logic       sfrRd;
   logic [7:0] sfrRdData;
   logic       decReq;
   logic       hdrLoad;
   logic       hdrVersion;
   logic [1:0] hdrRateCode;
   logic       layerErr;
   logic       syncErr;
   logic       crcErr;
   logic       ancValid;
   logic [7:0] ancByte;
   logic       decoderEnable;
   logic       bassBoost;
   logic       crcFramePlay;
   logic       frameSkip;
   logic [7:0] streamByte;
   logic       streamValid;
   logic       fillPending;
   logic       rateReserved;
   logic       decIrq;
   logic [7:0] rd;
   logic [7:0] streamSeen[$];
   int         skips;
   int         miscompares;
   int         checkCount;

   adhr_regs #(.FIRST_FILL(4)) u_adhr_regs (
      .clk(clk), .sys_rst(sysRst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .decReq(decReq),
      .hdrLoad(hdrLoad), .hdrVersion(hdrVersion), .hdrRateCode(hdrRateCode),
      .layerErr(layerErr), .syncErr(syncErr), .crcErr(crcErr),
      .ancValid(ancValid), .ancByte(ancByte), .decoderEnable(decoderEnable),
      .bassBoost(bassBoost), .crcFramePlay(crcFramePlay), .frameSkip(frameSkip),
      .streamByte(streamByte), .streamValid(streamValid),
      .fillPending(fillPending), .rateReserved(rateReserved), .decIrq(decIrq));
   adhr_dec_model u_adhr_dec_model (
      .clk(clk), .decReq(decReq), .hdrLoad(hdrLoad), .hdrVersion(hdrVersion),
      .hdrRateCode(hdrRateCode), .layerErr(layerErr), .syncErr(syncErr),
      .crcErr(crcErr), .ancValid(ancValid), .ancByte(ancByte));

   // ---------------------------------------------------------------
   // clock, monitors and bus tasks
   // ---------------------------------------------------------------
   initial clk = 1'b0;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (streamValid === 1'b1)
         streamSeen.push_back(streamByte);
      if (frameSkip === 1'b1)
         skips++;
   end
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfrAddr <= a;
      sfrWrData <= d;
      sfrWr <= 1'b1;
      @(posedge clk);
      sfrWr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      sfrAddr <= a;
      sfrRd <= 1'b1;
      @(posedge clk);
      sfrRd <= 1'b0;
      @(negedge clk);
      rd = sfrRdData;
   endtask
   // read issued in the cycle right after the write
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ra);
      wr(a, d);
      sfrAddr <= ra;
      sfrRd <= 1'b1;
      @(posedge clk);
      sfrRd <= 1'b0;
      @(negedge clk);
      rd = sfrRdData;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd_reg(adhr_pkg::ADDR_CONTROL);
      chk8("control", 8'h3F, rd);
      wr(adhr_pkg::ADDR_STATUS, 8'hFE);
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("status", 8'h01, rd);
      rd_reg(adhr_pkg::ADDR_AUX_STATUS);
      chk8("aux", 8'h10, rd);
      rd_reg(adhr_pkg::ADDR_ANCILLARY);
      chk8("anc", 8'h00, rd);
      wr(8'hAB, 8'h55);
      rd_reg(8'hAB);
      chk8("unmapped", 8'h00, rd);
      chk8("enable", 8'h00, {7'h00, decoderEnable});
      $display("test reset done");
   endtask
   task automatic t_control;
      wr(adhr_pkg::ADDR_CONTROL, 8'h40);
      wait_cyc(2);
      chk8("bass", 8'h01, {7'h00, bassBoost});
      chk8("enable", 8'h00, {7'h00, decoderEnable});
      rd_reg(adhr_pkg::ADDR_CONTROL);
      chk8("control", 8'h40, rd);
      wr(adhr_pkg::ADDR_CONTROL, 8'h1F);
      wait_cyc(2);
      chk8("bass", 8'h00, {7'h00, bassBoost});
      $display("test control done");
   endtask
   task automatic t_fill;
      wr(adhr_pkg::ADDR_CONTROL, 8'h9F);
      wait_cyc(2);
      chk8("enable", 8'h01, {7'h00, decoderEnable});
      chk8("fill", 8'h01, {7'h00, fillPending});
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("status", 8'h41, rd);
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("status", 8'h01, rd);
      rd_reg(adhr_pkg::ADDR_AUX_STATUS);
      chk8("aux", 8'h18, rd);
      wr_rd(adhr_pkg::ADDR_STREAM, 8'hA0, adhr_pkg::ADDR_AUX_STATUS);
      chk8("aux", 8'h10, rd);
      for (int i = 1; i < 4; i++) begin
         wait_cyc(1);
         chk8("fill", 8'h01, {7'h00, fillPending});
         wr(adhr_pkg::ADDR_STREAM, 8'hA0 + 8'(i));
      end
      wait_cyc(3);
      chk8("fill", 8'h00, {7'h00, fillPending});
      chk8("count", 8'h04, 8'(streamSeen.size()));
      foreach (streamSeen[i])
         chk8("stream", 8'hA0 + 8'(i), streamSeen[i]);
      rd_reg(adhr_pkg::ADDR_AUX_STATUS);
      chk8("aux", 8'h00, rd);
      u_adhr_dec_model.set_req(1'b1);
      wait_cyc(3);
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("status", 8'h41, rd);
      rd_reg(adhr_pkg::ADDR_AUX_STATUS);
      chk8("aux", 8'h18, rd);
      u_adhr_dec_model.set_req(1'b0);
      $display("test fill done");
   endtask
   task automatic t_err;
      for (int k = 0; k < 3; k++) begin
         u_adhr_dec_model.pulse_err(3'(1 << k));
         wait_cyc(3);
         rd_reg(adhr_pkg::ADDR_STATUS);
         chk8("flags", 8'h01 | 8'(8 << k), rd);
      end
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("flags", 8'h01, rd);
      chk8("skips", 8'h01, 8'(skips));
      wr(adhr_pkg::ADDR_CONTROL, 8'hBF);
      u_adhr_dec_model.pulse_err(3'h1);
      wait_cyc(3);
      chk8("skips", 8'h01, 8'(skips));
      chk8("play", 8'h01, {7'h00, crcFramePlay});
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("flags", 8'h09, rd);
      $display("test errors done");
   endtask
   task automatic t_hdr;
      for (int i = 0; i < 8; i++) begin
         u_adhr_dec_model.load_hdr(3'(i));
         wait_cyc(3);
         rd_reg(adhr_pkg::ADDR_STATUS);
         chk8("frame", {5'h00, 2'(i), 1'(i >> 2)}, rd);
         chk8("reserved", 8'(i % 4 == 3), {7'h00, rateReserved});
      end
      $display("test header done");
   endtask
   task automatic t_anc;
      u_adhr_dec_model.push_anc(8'hA1);
      u_adhr_dec_model.push_anc(8'hB2);
      u_adhr_dec_model.push_anc(8'hC3);
      wait_cyc(3);
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("ancflag", 8'h80, rd & 8'h80);
      for (int i = 0; i < 3; i++) begin
         rd_reg(adhr_pkg::ADDR_ANCILLARY);
         chk8("anc", 8'hA1 + 8'(i * 17), rd);
      end
      wait_cyc(2);
      rd_reg(adhr_pkg::ADDR_STATUS);
      chk8("ancflag", 8'h00, rd & 8'h80);
      rd_reg(adhr_pkg::ADDR_ANCILLARY);
      chk8("anc", 8'h00, rd);
      $display("test ancillary done");
   endtask
   task automatic t_irq;
      wr(adhr_pkg::ADDR_CONTROL, 8'h8F);
      wait_cyc(3);
      chk8("irq", 8'h00, {7'h00, decIrq});
      u_adhr_dec_model.push_anc(8'h5A);
      wait_cyc(4);
      chk8("irq", 8'h01, {7'h00, decIrq});
      rd_reg(adhr_pkg::ADDR_ANCILLARY);
      wait_cyc(3);
      chk8("irq", 8'h00, {7'h00, decIrq});
      wr(adhr_pkg::ADDR_CONTROL, 8'h9E);
      u_adhr_dec_model.pulse_err(3'h1);
      wait_cyc(4);
      chk8("irq", 8'h01, {7'h00, decIrq});
      rd_reg(adhr_pkg::ADDR_STATUS);
      wait_cyc(3);
      chk8("irq", 8'h00, {7'h00, decIrq});
      $display("test interrupt done");
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      miscompares = 0;
      checkCount = 0;
      skips = 0;
      sysRst = 1'b1;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      sfrWr = 1'b0;
      sfrRd = 1'b0;
      u_adhr_dec_model.idle();
      repeat (6) @(posedge clk);
      sysRst <= 1'b0;
      t_reset();
      t_control();
      t_fill();
      t_err();
      t_hdr();
      t_anc();
      t_irq();
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
